// ==== hw/srcs_receive_control.sv ====
// receive control and status register with its receiver, avalon slave and interrupt
// Operation
// - port enable cleared holds port in reset
// - ninth-bit select picks 9-bit or 8-bit characters
// - single receive in sync master, self-clearing
// - async: continuous receive switches receiver on/off
// - sync: continuous receive runs, overrides single receive
// - async 9-bit address detect: accept ninth=1 only
// - async 9-bit without detect: accept all characters
// - async 8-bit ignores address detect
// - framing flag refreshed on next character loaded into the buffer (not on overrun)
// - overrun flag set, cleared by clearing continuous receive
module srcs_receive_control (
  input  wire logic                        sys_clk,
  input  wire logic                        reset,
  input  wire logic [srcs_pkg::ADDR_W-1:0] avs_address,
  input  wire logic                        avs_read,
  input  wire logic                        avs_write,
  input  wire logic [31:0]                 avs_writedata,
  output logic      [31:0]                 avs_readdata,
  output logic                             avs_waitrequest,
  input  wire logic                        receive_or_sync_data_pin,
  input  wire logic                        transmit_or_sync_clock_pin_in,
  output logic                             transmit_or_sync_clock_pin_out,
  output logic                             transmit_or_sync_clock_pin_oe,
  output logic                             irq
);
  import srcs_pkg::*;

  function automatic logic hitReg(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] off);
    hitReg = (a == off);
  endfunction

  // bus state
  logic                ack_q, ack_d;
  logic [31:0]         rdata_q, rdata_d;
  // core state
  srcs_ctrl_t          ctrl_q, ctrl_d;
  logic [1:0]          mode_q, mode_d;
  logic                receive_interrupt_flag_q, receive_interrupt_flag_d;
  logic [7:0]          rxBuf_q, rxBuf_d;
  logic [IRQ_W-1:0]    irqStat_q, irqStat_d;
  logic [IRQ_W-1:0]    irqEn_q, irqEn_d;
  srcs_state_t         state_q, state_d;
  logic [CNT_W-1:0]    cnt_q, cnt_d;
  logic [3:0]          bitIdx_q, bitIdx_d;
  logic [8:0]          shift_q, shift_d;
  logic                mclk_q, mclk_d;
  logic [1:0]          rxSync_q, rxSync_d;
  logic [1:0]          ckSync_q, ckSync_d;
  logic                ckPrev_q, ckPrev_d;

  logic                wrAcc, rdAcc;
  logic                isSync, isMaster, rxOn, sampleEdge, charDone;
  logic [3:0]          nBits;
  srcs_char_t          rxChar;
  logic                accept;
  logic [IRQ_W-1:0]    irqEvt;
  srcs_ctrl_t          wrCtrl;

  assign wrAcc = avs_write & ack_q;
  assign rdAcc = avs_read & ack_q;
  assign wrCtrl = srcs_ctrl_t'(avs_writedata[7:0]);
  assign avs_waitrequest = (avs_read | avs_write) & ~ack_q;
  assign avs_readdata = rdata_q;
  assign irq = |(irqStat_q & irqEn_q);
  assign isSync = mode_q[MODE_SYNC_BIT];
  assign isMaster = mode_q[MODE_MASTER_BIT];
  assign nBits = ctrl_q.ninthBitReceiveSelect ? BITS_9 : BITS_8;
  assign transmit_or_sync_clock_pin_out = mclk_q;
  assign transmit_or_sync_clock_pin_oe = ctrl_q.serialPortEnable & isSync & isMaster;

  // bus answer: request seen, data registered, waitrequest drops next cycle
  always_comb begin
    ack_d = (avs_read | avs_write) & ~ack_q;
    rdata_d = rdata_q;
    if (avs_read & ~ack_q) begin
      rdata_d = '0;
      if (hitReg(avs_address, REG_CTRL)) begin
        rdata_d[7:0] = ctrl_q;
      end else if (hitReg(avs_address, REG_DATA)) begin
        rdata_d[7:0] = rxBuf_q;
      end else if (hitReg(avs_address, REG_MODE)) begin
        rdata_d[1:0] = mode_q;
        rdata_d[MODE_RECEIVE_INTERRUPT_FLAG_BIT] = receive_interrupt_flag_q;
      end else if (hitReg(avs_address, REG_IRQ_STATUS)) begin
        rdata_d[IRQ_W-1:0] = irqStat_q;
      end else if (hitReg(avs_address, REG_IRQ_ENABLE)) begin
        rdata_d[IRQ_W-1:0] = irqEn_q;
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      ack_q   <= 1'b0;
      rdata_q <= '0;
    end else begin
      ack_q   <= ack_d;
      rdata_q <= rdata_d;
    end
  end

  // receiver on/off per mode
  always_comb begin
    if (!ctrl_q.serialPortEnable) begin
      rxOn = 1'b0;
    end else if (isSync && isMaster) begin
      rxOn = ctrl_q.continuousReceiveEnable | ctrl_q.singleReceiveEnable;
    end else begin
      rxOn = ctrl_q.continuousReceiveEnable;
    end
  end

  // sync sample point: own clock rising in master, pin clock rising in slave
  always_comb begin
    if (isMaster) begin
      sampleEdge = (state_q == ST_DATA) && (cnt_q == '0) && !mclk_q;
    end else begin
      sampleEdge = ckSync_q[1] & ~ckPrev_q;
    end
  end

  always_comb begin
    rxSync_d = {rxSync_q[0], receive_or_sync_data_pin};
    ckSync_d = {ckSync_q[0], transmit_or_sync_clock_pin_in};
    ckPrev_d = ckSync_q[1];
    state_d  = state_q;
    cnt_d    = cnt_q;
    bitIdx_d = bitIdx_q;
    shift_d  = shift_q;
    mclk_d   = mclk_q;
    charDone = 1'b0;
    rxChar.ninth    = 1'b0;
    rxChar.data     = nBits == BITS_9 ? shift_q[7:0] : shift_q[8:1];
    rxChar.frameErr = 1'b0;
    if (nBits == BITS_9) begin
      rxChar.ninth = shift_q[8];
    end
    case (state_q)
      ST_IDLE: begin
        mclk_d = 1'b0;
        bitIdx_d = '0;
        if (rxOn && isSync) begin
          state_d = ST_DATA;
          cnt_d = CNT_W'(MCLK_HALF_CYCLES - 1);
        end else if (rxOn && !rxSync_q[1]) begin
          state_d = ST_START;
          cnt_d = CNT_W'(HALF_BIT_CYCLES);
        end
      end
      ST_START: begin
        cnt_d = cnt_q - 1'b1;
        if (cnt_q == '0) begin
          cnt_d = CNT_W'(BIT_CYCLES - 1);
          state_d = rxSync_q[1] ? ST_IDLE : ST_DATA;
        end
      end
      ST_DATA: begin
        if (isSync) begin
          if (isMaster) begin
            cnt_d = cnt_q - 1'b1;
            if (cnt_q == '0) begin
              cnt_d = CNT_W'(MCLK_HALF_CYCLES - 1);
              mclk_d = ~mclk_q;
            end
          end
          if (sampleEdge) begin
            shift_d = {rxSync_q[1], shift_q[8:1]};
            bitIdx_d = bitIdx_q + 1'b1;
            if (bitIdx_q == nBits - 1'b1) begin
              state_d = ST_STOP;
            end
          end
        end else begin
          cnt_d = cnt_q - 1'b1;
          if (cnt_q == '0) begin
            cnt_d = CNT_W'(BIT_CYCLES - 1);
            shift_d = {rxSync_q[1], shift_q[8:1]};
            bitIdx_d = bitIdx_q + 1'b1;
            if (bitIdx_q == nBits - 1'b1) begin
              state_d = ST_STOP;
            end
          end
        end
      end
      ST_STOP: begin
        if (isSync) begin
          // master keeps the last high phase full length before closing
          if (isMaster) begin
            cnt_d = cnt_q - 1'b1;
          end
          if (!isMaster || cnt_q == '0) begin
            charDone = 1'b1;
            state_d = ST_IDLE;
            mclk_d = 1'b0;
          end
        end else begin
          cnt_d = cnt_q - 1'b1;
          if (cnt_q == '0) begin
            charDone = 1'b1;
            rxChar.frameErr = ~rxSync_q[1];
            state_d = ST_IDLE;
          end
        end
      end
      default: begin
        state_d = ST_IDLE;
      end
    endcase
    if (!rxOn) begin
      state_d = ST_IDLE;
      mclk_d = 1'b0;
    end
  end

  // address filter applies only to 9-bit async reception
  always_comb begin
    accept = charDone;
    if (!isSync && ctrl_q.ninthBitReceiveSelect && ctrl_q.addressDetectEnable) begin
      accept = charDone & rxChar.ninth;
    end // otherwise every character passes
  end

  always_comb begin
    ctrl_d  = ctrl_q;
    mode_d  = mode_q;
    receive_interrupt_flag_d  = receive_interrupt_flag_q;
    rxBuf_d = rxBuf_q;
    irqEn_d = irqEn_q;
    irqEvt  = '0;
    irqStat_d = irqStat_q;
    if (wrAcc && hitReg(avs_address, REG_CTRL)) begin
      ctrl_d.serialPortEnable        = wrCtrl.serialPortEnable;
      ctrl_d.ninthBitReceiveSelect   = wrCtrl.ninthBitReceiveSelect;
      ctrl_d.singleReceiveEnable     = wrCtrl.singleReceiveEnable;
      ctrl_d.continuousReceiveEnable = wrCtrl.continuousReceiveEnable;
      ctrl_d.addressDetectEnable     = wrCtrl.addressDetectEnable;
      if (!wrCtrl.continuousReceiveEnable) begin
        ctrl_d.overrunErrorFlag = 1'b0;
      end
    end
    if (wrAcc && hitReg(avs_address, REG_MODE)) begin
      mode_d = avs_writedata[1:0];
    end
    if (wrAcc && hitReg(avs_address, REG_IRQ_ENABLE)) begin
      irqEn_d = avs_writedata[IRQ_W-1:0];
    end
    if (wrAcc && hitReg(avs_address, REG_IRQ_CLEAR)) begin
      irqStat_d = irqStat_q & ~avs_writedata[IRQ_W-1:0];
    end
    if (rdAcc && hitReg(avs_address, REG_DATA)) begin
      receive_interrupt_flag_d = 1'b0;
    end
    if (charDone && isSync && isMaster && !ctrl_q.continuousReceiveEnable) begin
      ctrl_d.singleReceiveEnable = 1'b0;
    end
    if (accept && !ctrl_q.overrunErrorFlag) begin
      if (receive_interrupt_flag_q && !(rdAcc && hitReg(avs_address, REG_DATA))) begin
        ctrl_d.overrunErrorFlag = 1'b1;
        irqEvt[IRQ_OVERRUN] = 1'b1;
      end else begin
        rxBuf_d = rxChar.data;
        receive_interrupt_flag_d = 1'b1;
        ctrl_d.framingErrorFlag = rxChar.frameErr;
        ctrl_d.receivedNinthBit = rxChar.ninth;
        irqEvt[IRQ_READY] = 1'b1;
        irqEvt[IRQ_FRAMING] = rxChar.frameErr;
      end
    end
    irqStat_d = irqStat_d | irqEvt;
    if (!ctrl_q.serialPortEnable) begin
      receive_interrupt_flag_d = 1'b0;
      ctrl_d.framingErrorFlag = 1'b0;
      ctrl_d.overrunErrorFlag = 1'b0;
      ctrl_d.receivedNinthBit = 1'b0;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      ctrl_q    <= srcs_ctrl_t'(CTRL_RESET);
      mode_q    <= MODE_RESET;
      receive_interrupt_flag_q    <= 1'b0;
      rxBuf_q   <= '0;
      irqStat_q <= '0;
      irqEn_q   <= '0;
      state_q   <= ST_IDLE;
      cnt_q     <= '0;
      bitIdx_q  <= '0;
      shift_q   <= '0;
      mclk_q    <= 1'b0;
      rxSync_q  <= 2'h3;
      ckSync_q  <= '0;
      ckPrev_q  <= 1'b0;
    end else begin
      ctrl_q    <= ctrl_d;
      mode_q    <= mode_d;
      receive_interrupt_flag_q    <= receive_interrupt_flag_d;
      rxBuf_q   <= rxBuf_d;
      irqStat_q <= irqStat_d;
      irqEn_q   <= irqEn_d;
      state_q   <= state_d;
      cnt_q     <= cnt_d;
      bitIdx_q  <= bitIdx_d;
      shift_q   <= shift_d;
      mclk_q    <= mclk_d;
      rxSync_q  <= rxSync_d;
      ckSync_q  <= ckSync_d;
      ckPrev_q  <= ckPrev_d;
    end
  end
endmodule // srcs_receive_control

// ==== include/srcs_pkg.sv ====
// constants and types of the serial receive control and status block
package srcs_pkg;
  // avalon byte offsets
  localparam int          ADDR_W         = 8;
  localparam logic [7:0]  REG_CTRL       = 8'h00;
  localparam logic [7:0]  REG_DATA       = 8'h04;
  localparam logic [7:0]  REG_MODE       = 8'h08;
  localparam logic [7:0]  REG_IRQ_STATUS = 8'h0C;
  localparam logic [7:0]  REG_IRQ_ENABLE = 8'h10;
  localparam logic [7:0]  REG_IRQ_CLEAR  = 8'h14;

  localparam logic [7:0]  CTRL_RESET     = 8'h00;
  localparam logic [1:0]  MODE_RESET     = 2'h0;
  localparam int          MODE_SYNC_BIT  = 0;
  localparam int          MODE_MASTER_BIT = 1;
  localparam int          MODE_RECEIVE_INTERRUPT_FLAG_BIT  = 2;

  localparam int          IRQ_W          = 3;
  localparam int          IRQ_READY      = 0;
  localparam int          IRQ_FRAMING    = 1;
  localparam int          IRQ_OVERRUN    = 2;

  // timing
  localparam int          CLK_PERIOD_NS  = 4;
  localparam int          BIT_TIME_NS    = 1000;
  localparam int          MCLK_HALF_NS   = 128;
  localparam int          BIT_CYCLES     = BIT_TIME_NS / CLK_PERIOD_NS;
  localparam int          HALF_BIT_CYCLES = BIT_CYCLES / 2;
  localparam int          MCLK_HALF_CYCLES = MCLK_HALF_NS / CLK_PERIOD_NS;
  localparam int          CNT_W          = 9;
  localparam logic [3:0]  BITS_8         = 4'h8;
  localparam logic [3:0]  BITS_9         = 4'h9;

  // field order gives bit 7 down to bit 0
  typedef struct packed {
    logic serialPortEnable;
    logic ninthBitReceiveSelect;
    logic singleReceiveEnable;
    logic continuousReceiveEnable;
    logic addressDetectEnable;
    logic framingErrorFlag;
    logic overrunErrorFlag;
    logic receivedNinthBit;
  } srcs_ctrl_t;

  typedef struct packed {
    logic       ninth;
    logic [7:0] data;
    logic       frameErr;
  } srcs_char_t;

  typedef enum logic [1:0] {
    ST_IDLE  = 2'h0,
    ST_START = 2'h1,
    ST_DATA  = 2'h3,
    ST_STOP  = 2'h2
  } srcs_state_t;
endpackage

// ==== tb/srcs_receive_control_props.sv ====
// port checks of the receive control block
module srcs_receive_control_props (
  input wire logic                        sys_clk,
  input wire logic                        reset,
  input wire logic [srcs_pkg::ADDR_W-1:0] avs_address,
  input wire logic                        avs_read,
  input wire logic                        avs_write,
  input wire logic [31:0]                 avs_writedata,
  input wire logic [31:0]                 avs_readdata,
  input wire logic                        avs_waitrequest,
  input wire logic                        transmit_or_sync_clock_pin_out,
  input wire logic                        transmit_or_sync_clock_pin_oe,
  input wire logic                        irq
);
  timeunit 1ns;
  timeprecision 1ps;
  import srcs_pkg::*;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (reset);
  a_wait_one:
    assert property ((avs_read || avs_write) && !$past(avs_read || avs_write)
      |-> avs_waitrequest ##1 !avs_waitrequest) else $error("wait not one cycle");
  a_wait_idle:
    assert property (!(avs_read || avs_write) |-> !avs_waitrequest) else $error("idle wait");
  a_reset_quiet:
    assert property ($fell(reset) |-> !irq && !transmit_or_sync_clock_pin_oe
      && avs_readdata == 32'h0) else $error("outputs not quiet after reset");
  a_unmapped_zero:
    assert property (avs_read && !avs_waitrequest && avs_address > REG_IRQ_CLEAR
      |-> avs_readdata == 32'h0) else $error("unmapped read not zero");
  a_upper_zero:
    assert property (avs_read && !avs_waitrequest |-> avs_readdata[31:8] == 24'h0)
      else $error("upper read bits set");
  a_idle_clock:
    assert property (!transmit_or_sync_clock_pin_oe |-> !transmit_or_sync_clock_pin_out)
      else $error("clock out while not driven");
  a_high_phase:
    assert property ($rose(transmit_or_sync_clock_pin_out)
      |-> transmit_or_sync_clock_pin_out[*8]) else $error("clock high too short");
  a_irq_mask:
    assert property (avs_write && !avs_waitrequest && avs_address == REG_IRQ_ENABLE
      && avs_writedata[2:0] == 3'h0 |=> !irq) else $error("irq not masked");
endmodule // srcs_receive_control_props

bind srcs_receive_control srcs_receive_control_props i_props (
  .sys_clk, .reset, .avs_address, .avs_read, .avs_write, .avs_writedata, .avs_readdata,
  .avs_waitrequest, .transmit_or_sync_clock_pin_out, .transmit_or_sync_clock_pin_oe, .irq
);

// ==== tb/srcs_remote_station.sv ====
// remote serial station driving the data line and the slave clock
module srcs_remote_station (
  output logic      dataLine,
  output logic      slaveClk,
  input  wire logic masterClk
);
  timeunit 1ns;
  timeprecision 1ps;
  import srcs_pkg::*;
  initial dataLine = 1'b1;
  initial slaveClk = 1'b0;
  // start low, lsb first, chosen stop level, one idle bit high
  task automatic async_tx(input logic [8:0] v, input int n, input logic stp);
    dataLine = 1'b0;
    #(BIT_TIME_NS);
    for (int i = 0; i < n; i++) begin
      dataLine = v[i];
      #(BIT_TIME_NS);
    end
    dataLine = stp;
    #(BIT_TIME_NS);
    dataLine = 1'b1;
    #(BIT_TIME_NS);
  endtask
  // data changes on falling clock, released line shows inverse
  task automatic master_rx(input logic [8:0] v, input int n);
    for (int i = 0; i < n; i++) begin
      dataLine = v[i];
      @(posedge masterClk);
      if (i < n - 1) @(negedge masterClk);
    end
    dataLine = ~dataLine;
  endtask
  // 64 ns clock only within the character
  task automatic slave_tx(input logic [8:0] v, input int n);
    for (int i = 0; i < n; i++) begin
      dataLine = v[i];
      #32 slaveClk = 1'b1;
      #32 slaveClk = 1'b0;
    end
    dataLine = ~dataLine;
  endtask
endmodule // srcs_remote_station

// ==== tb/srcs_receive_control_bench.sv ====
// self-checking bench of the receive control block
`define CHK(got, exp) begin tests_run++; if ((got) !== (exp)) begin fails++; \
  $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp); end end
module srcs_receive_control_bench;
  timeunit 1ns;
  timeprecision 1ps;
  import srcs_pkg::*;
  logic        sys_clk = 1'b0;
  logic        reset = 1'b1;
  logic        avs_read = 1'b0;
  logic        avs_write = 1'b0;
  logic [7:0]  avs_address = 8'h00;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata, rd, d;
  logic        avs_waitrequest, irq, rxLine, slaveClk, clkOut, clkOe;
  logic [7:0]  c;
  logic [31:0] rngState = 32'h2C;
  int          fails = 0;
  int          tests_run = 0;
  wire logic   clkWire = clkOe ? clkOut : slaveClk;

  srcs_receive_control i_dut (
    .sys_clk, .reset, .avs_address, .avs_read, .avs_write, .avs_writedata,
    .avs_readdata, .avs_waitrequest, .receive_or_sync_data_pin(rxLine),
    .transmit_or_sync_clock_pin_in(clkWire), .transmit_or_sync_clock_pin_out(clkOut),
    .transmit_or_sync_clock_pin_oe(clkOe), .irq
  );
  srcs_remote_station i_rem (.dataLine(rxLine), .slaveClk, .masterClk(clkWire));

  function automatic logic [31:0] rnd();
    rngState ^= rngState << 13;
    rngState ^= rngState >> 17;
    rngState ^= rngState << 5;
    return rngState;
  endfunction
  function automatic logic accepted(input logic [7:0] cv, input logic n9);
    return !(cv[6] && cv[3]) || n9;
  endfunction
  // request held until the rising edge that sees waitrequest low; data taken there
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] v);
    avs_read <= ~w;
    avs_write <= w;
    avs_address <= a;
    avs_writedata <= v;
    do begin
      @(posedge sys_clk);
    end while (avs_waitrequest !== 1'b0);
    rd = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    @(posedge sys_clk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    bus(1'b1, a, v);
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    `CHK(rd, e)
  endtask
  task automatic send(input logic [8:0] v, input int n, input logic stp);
    i_rem.async_tx(v, n, stp);
    @(posedge sys_clk);
  endtask
  task automatic wait_irq();
    for (int k = 0; k < 3000; k++) begin
      @(posedge sys_clk);
      if (irq === 1'b1) break;
    end
  endtask
  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  initial forever #(CLK_PERIOD_NS / 2) sys_clk = ~sys_clk;
  initial begin
    #300us;
    fails++;
    finish_test();
  end
  initial begin
    repeat (6) @(posedge sys_clk);
    reset <= 1'b0;
    @(posedge sys_clk);
    rdc(REG_CTRL, 32'h0);
    rdc(8'h18, 32'h0);
    wr(REG_IRQ_ENABLE, 32'h7);
    repeat (8) begin
      d = rnd();
      c = {1'b1, d[30], 2'b01, d[29], 3'h0};
      wr(REG_CTRL, {24'h0, c});
      wr(REG_IRQ_CLEAR, 32'h7);
      send(d[8:0], c[6] ? 9 : 8, 1'b1);
      rdc(REG_IRQ_STATUS, {31'h0, accepted(c, d[8])});
      if (accepted(c, d[8])) begin
        rdc(REG_DATA, {24'h0, d[7:0]});
        rdc(REG_CTRL, {24'h0, c[7:3], 2'h0, c[6] & d[8]});
      end
    end
    wr(REG_CTRL, 32'h90);
    wr(REG_IRQ_CLEAR, 32'h7);
    send(9'h0A5, 8, 1'b0);
    rdc(REG_CTRL, 32'h94);
    rdc(REG_IRQ_STATUS, 32'h3);
    rdc(REG_DATA, 32'hA5);
    wr(REG_IRQ_ENABLE, 32'h0);
    `CHK(irq, 1'b0)
    wr(REG_IRQ_ENABLE, 32'h7);
    `CHK(irq, 1'b1)
    wr(REG_IRQ_CLEAR, 32'h7);
    `CHK(irq, 1'b0)
    send(9'h03C, 8, 1'b1);
    rdc(REG_CTRL, 32'h90);
    send(9'h055, 8, 1'b1);
    rdc(REG_CTRL, 32'h92);
    rdc(REG_DATA, 32'h3C);
    send(9'h066, 8, 1'b1);
    rdc(REG_DATA, 32'h3C);
    wr(REG_CTRL, 32'h90);
    rdc(REG_CTRL, 32'h92);
    wr(REG_CTRL, 32'h80);
    rdc(REG_CTRL, 32'h80);
    wr(REG_IRQ_CLEAR, 32'h7);
    send(9'h077, 8, 1'b1);
    rdc(REG_IRQ_STATUS, 32'h0);
    wr(REG_CTRL, 32'hD8);
    send(9'h012, 9, 1'b1);
    rdc(REG_IRQ_STATUS, 32'h0);
    send(9'h1AB, 9, 1'b1);
    rdc(REG_CTRL, 32'hD9);
    wr(REG_CTRL, 32'h58);
    rdc(REG_CTRL, 32'h58);
    wr(REG_MODE, 32'h3);
    wr(REG_IRQ_CLEAR, 32'h7);
    wr(REG_CTRL, 32'hA0);
    d = rnd();
    i_rem.master_rx(d[8:0], 8);
    wait_irq();
    rdc(REG_DATA, {24'h0, d[7:0]});
    rdc(REG_CTRL, 32'h80);
    wr(REG_MODE, 32'h1);
    wr(REG_CTRL, 32'hB0);
    repeat (2) begin
      d = rnd();
      wr(REG_IRQ_CLEAR, 32'h7);
      i_rem.slave_tx(d[8:0], 8);
      wait_irq();
      rdc(REG_DATA, {24'h0, d[7:0]});
    end
    finish_test();
  end
endmodule // srcs_receive_control_bench
